/* core/gpx_pkg.sv */
// Constants shared by the I2C port expander core and its link engine.
// Assumes an I2C master on the far side and a free-running system clock.
package gpx_pkg;
  // Fixed upper address bits, straps fill the two below them
  localparam logic [4:0] ADDR_FIXED     = 5'h1C;
  // Register offsets, equal to the command codes
  localparam logic [7:0] OFS_IN         = 8'h00;
  localparam logic [7:0] OFS_OUT        = 8'h01;
  localparam logic [7:0] OFS_INV        = 8'h02;
  localparam logic [7:0] OFS_DIR        = 8'h03;
  localparam logic [7:0] OFS_DRV0       = 8'h40;
  localparam logic [7:0] OFS_DRV1       = 8'h41;
  localparam logic [7:0] OFS_HOLD       = 8'h42;
  localparam logic [7:0] OFS_PEN        = 8'h43;
  localparam logic [7:0] OFS_PDIR       = 8'h44;
  localparam logic [7:0] OFS_MASK       = 8'h45;
  localparam logic [7:0] OFS_FLAGS      = 8'h46;
  localparam logic [7:0] OFS_STAGE      = 8'h4F;
  // Reset values
  localparam logic [7:0] RST_OUT        = 8'hFF;
  localparam logic [7:0] RST_INV        = 8'h00;
  localparam logic [7:0] RST_DIR        = 8'hFF;
  localparam logic [7:0] RST_DRV        = 8'hFF;
  localparam logic [7:0] RST_HOLD       = 8'h00;
  localparam logic [7:0] RST_PEN        = 8'h00;
  localparam logic [7:0] RST_PDIR       = 8'hFF;
  localparam logic [7:0] RST_MASK       = 8'hFF;
  localparam logic [7:0] RST_STAGE      = 8'h00;
  // Open-drain bank select bit of the stage register
  localparam int         STAGE_OD_BIT   = 0;
  // System cycles until the pin synchronisers hold real levels
  localparam logic [2:0] SETTLE_CYC     = 3'h5;
endpackage

/* core/gpx_link_if.sv */
// Carrier between the link engine (bus clock) and the register core.
// Each toggle marks one event; its data stays put until the next toggle.
`timescale 1ns/1ps
`default_nettype none
interface gpx_link_if;
  logic       wr_tgl;
  logic       wr_cmd;
  logic [7:0] wr_byte;
  logic       rdq_tgl;
  logic       rdd_tgl;
  logic [7:0] rd_byte;
  logic [1:0] strap;
  modport link (output wr_tgl, output wr_cmd, output wr_byte, output rdq_tgl,
                output rdd_tgl, input rd_byte, input strap);
  modport core (input wr_tgl, input wr_cmd, input wr_byte, input rdq_tgl,
                input rdd_tgl, output rd_byte, output strap);
endinterface
`default_nettype wire

/* core/gpx_i2c_link.sv */
// I2C slave bit engine, clocked by the bus clock itself.
// Assumes the bus clock is slow enough for the core to answer a prefetch
// within eight bus clock periods.
`timescale 1ns/1ps
`default_nettype none
module gpx_i2c_link (
  // Bus clock and reset
  input  wire logic   scl_i,
  input  wire logic   rst_n,
  // Data line
  input  wire logic   sda_i,
  output logic        sda_oe,
  // Core side
  gpx_link_if.link    lk
);
  import gpx_pkg::*;

  typedef enum logic [2:0] {L_IDLE, L_ADDR, L_AACK, L_WDATA, L_WACK, L_RDATA, L_RACK} link_st_t;
  typedef struct packed {
    link_st_t   st;
    logic [2:0] cnt;
    logic [7:0] sh;
    logic       rw;
    logic       first;
    logic       start_seen;
    logic       wr_tgl;
    logic       wr_cmd;
    logic [7:0] wr_byte;
    logic       rdq_tgl;
    logic       rdd_tgl;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
  } link_state_t;

  link_state_t q;
  link_state_t d;
  logic        start_tgl;
  logic        oe_q;

  ////////////////////////////////////////////////////////////////////////////
  // Start: SDA falls while SCL is high; settled long before the next SCL rise
  always_ff @(negedge sda_i or negedge rst_n) begin
    if (!rst_n) begin
      start_tgl <= 1'b0;
    end else if (scl_i) begin
      start_tgl <= ~start_tgl;
    end
  end

  always_comb begin
    d = q;
    d.strap_s1 = lk.strap;
    d.strap_s2 = q.strap_s1;
    d.start_seen = start_tgl;
    d.cnt = q.cnt + 3'h1;
    if (start_tgl != q.start_seen) begin
      // Read data fetched ahead: the first data bit leaves eight clocks later
      d.st = L_ADDR;
      d.cnt = 3'h1;
      d.sh = {q.sh[6:0], sda_i};
      d.rdq_tgl = ~q.rdq_tgl;
    end else begin
      unique case (q.st)
        L_IDLE: d.cnt = 3'h0;
        L_ADDR: begin
          d.sh = {q.sh[6:0], sda_i};
          if (q.cnt == 3'h7) begin
            d.rw = sda_i;
            d.st = (q.sh[6:0] == {ADDR_FIXED, q.strap_s2}) ? L_AACK : L_IDLE;
          end
        end
        L_AACK: begin
          d.cnt = 3'h0;
          if (q.rw) begin
            d.st = L_RDATA;
            d.sh = lk.rd_byte;
            d.rdq_tgl = ~q.rdq_tgl;
          end else begin
            d.st = L_WDATA;
            d.first = 1'b1;
          end
        end
        L_WDATA: begin
          d.sh = {q.sh[6:0], sda_i};
          if (q.cnt == 3'h7) begin
            d.wr_byte = {q.sh[6:0], sda_i};
            d.wr_cmd = q.first;
            d.wr_tgl = ~q.wr_tgl;
            d.st = L_WACK;
          end
        end
        L_WACK: begin
          d.st = L_WDATA;
          d.first = 1'b0;
          d.cnt = 3'h0;
        end
        L_RDATA: begin
          d.sh = {q.sh[6:0], 1'b0};
          if (q.cnt == 3'h7) begin
            d.st = L_RACK;
            d.rdd_tgl = ~q.rdd_tgl;
          end
        end
        L_RACK: begin
          d.cnt = 3'h0;
          d.st = sda_i ? L_IDLE : L_RDATA;
          if (!sda_i) begin
            d.sh = lk.rd_byte;
            d.rdq_tgl = ~q.rdq_tgl;
          end
        end
        default: d.st = L_IDLE;
      endcase
    end
  end

  always_ff @(posedge scl_i or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // Data line only changes while SCL is low
  always_ff @(negedge scl_i or negedge rst_n) begin
    if (!rst_n) begin
      oe_q <= 1'b0;
    end else begin
      oe_q <= (q.st == L_AACK) || (q.st == L_WACK) || (q.st == L_RDATA && !q.sh[7]);
    end
  end

  assign sda_oe = oe_q;
  assign lk.wr_tgl = q.wr_tgl;
  assign lk.wr_cmd = q.wr_cmd;
  assign lk.wr_byte = q.wr_byte;
  assign lk.rdq_tgl = q.rdq_tgl;
  assign lk.rdd_tgl = q.rdd_tgl;

  addr_match_a: assert property (@(posedge scl_i) disable iff (!rst_n)
    (q.st == L_ADDR && q.cnt == 3'h7 && start_tgl == q.start_seen &&
     q.sh[6:0] != {ADDR_FIXED, q.strap_s2}) |=> (q.st == L_IDLE))
    else $error("address mismatch was acknowledged");
endmodule
`default_nettype wire

/* core/gpx_expander.sv */
// Register core and pin logic of the 8-bit I2C port expander (top level).
// Assumes a free-running system clock much faster than the bus clock;
// SCL clocks the link engine, everything else runs on CLK_SYS.
`timescale 1ns/1ps
`default_nettype none
module gpx_expander (
  // System clock and reset
  input  wire logic       CLK_SYS,
  input  wire logic       RSTN,
  // I2C bus
  input  wire logic       SCL,
  input  wire logic       SDA_I,
  output logic            SDA_O,
  output logic            SDA_OE,
  // Address straps
  input  wire logic       ADDR_STRAP_LO,
  input  wire logic       ADDR_STRAP_HI,
  // Port pins
  input  wire logic [7:0] PORT_PIN_I,
  output logic [7:0]      PORT_PIN_O,
  output logic [7:0]      PORT_PIN_OE,
  // Pad controls
  output logic [15:0]     PAD_DRIVE,
  output logic [7:0]      PAD_PULL_EN,
  output logic [7:0]      PAD_PULL_UP,
  // Interrupt, active low, open drain
  output logic            INT_N_O,
  output logic            INT_N_OE
);
  import gpx_pkg::*;

  typedef struct packed {
    logic [7:0] ptr;
    logic [7:0] outr;
    logic [7:0] inv;
    logic [7:0] dir;
    logic [7:0] drv0;
    logic [7:0] drv1;
    logic [7:0] hold;
    logic [7:0] pen;
    logic [7:0] pdir;
    logic [7:0] mask;
    logic [7:0] stage;
    logic [7:0] shadow;
    logic [7:0] rd_byte;
    logic [7:0] rd_sent;
    logic [2:0] init_cnt;
    logic [7:0] pin_s1;
    logic [7:0] pin_s2;
    logic [7:0] pin_s3;
    logic [7:0] pin_f;
    logic [1:0] strap_s1;
    logic [1:0] strap_s2;
    logic [1:0] strap_s3;
    logic [1:0] strap_f;
    logic [2:0] tg_s1;
    logic [2:0] tg_s2;
    logic [2:0] tg_s3;
    logic [2:0] tg_f;
    logic [7:0] port_oe;
    logic       int_oe;
    logic       low;
  } core_state_t;

  core_state_t q;
  core_state_t d;
  logic [7:0]  sensed;
  logic [7:0]  flags;
  logic [2:0]  ev;
  logic [7:0]  tg_new;
  logic [7:0]  strap_new;
  gpx_link_if  lk ();

  // Take the settled level once the last two stages agree
  function automatic logic [7:0] settle(input logic [7:0] s2, input logic [7:0] s3,
                                        input logic [7:0] f);
    logic [7:0] moving;
    moving = s2 ^ s3;
    settle = (~moving & s3) | (moving & f);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link engine on the bus clock

  gpx_i2c_link u_link (
    .scl_i  (SCL),
    .rst_n  (RSTN),
    .sda_i  (SDA_I),
    .sda_oe (SDA_OE),
    .lk     (lk.link)
  );

  assign lk.rd_byte = q.rd_byte;
  assign lk.strap = q.strap_f;

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    d = q;
    d.low = 1'b0;
    // Pins, straps and link toggles all cross through three stages
    d.pin_s1 = PORT_PIN_I;
    d.pin_s2 = q.pin_s1;
    d.pin_s3 = q.pin_s2;
    d.pin_f = settle(q.pin_s2, q.pin_s3, q.pin_f);
    d.strap_s1 = {ADDR_STRAP_HI, ADDR_STRAP_LO};
    d.strap_s2 = q.strap_s1;
    d.strap_s3 = q.strap_s2;
    strap_new = settle({6'h00, q.strap_s2}, {6'h00, q.strap_s3}, {6'h00, q.strap_f});
    d.strap_f = strap_new[1:0];
    d.tg_s1 = {lk.rdd_tgl, lk.rdq_tgl, lk.wr_tgl};
    d.tg_s2 = q.tg_s1;
    d.tg_s3 = q.tg_s2;
    tg_new = settle({5'h00, q.tg_s2}, {5'h00, q.tg_s3}, {5'h00, q.tg_f});
    d.tg_f = tg_new[2:0];
    ev = d.tg_f ^ q.tg_f;

    sensed = q.pin_f ^ q.inv;
    flags = (sensed ^ q.shadow) & q.dir & ~q.mask;

    // Until the synchronisers are filled, the compare value tracks the sensed pins
    if (q.init_cnt != SETTLE_CYC) begin
      d.init_cnt = q.init_cnt + 3'h1;
      d.shadow = sensed;
    end

    // Write from the link: command byte loads the pointer, data bytes the target
    if (ev[0]) begin
      if (lk.wr_cmd) begin
        d.ptr = lk.wr_byte;
      end else begin
        case (q.ptr)
          OFS_OUT:   d.outr = lk.wr_byte;
          OFS_INV:   d.inv = lk.wr_byte;
          OFS_DIR:   d.dir = lk.wr_byte;
          OFS_DRV0:  d.drv0 = lk.wr_byte;
          OFS_DRV1:  d.drv1 = lk.wr_byte;
          OFS_HOLD:  d.hold = lk.wr_byte;
          OFS_PEN:   d.pen = lk.wr_byte;
          OFS_PDIR:  d.pdir = lk.wr_byte;
          OFS_MASK:  d.mask = lk.wr_byte;
          OFS_STAGE: d.stage = lk.wr_byte;
          // Input port, flags and unknown codes: byte acknowledged, then dropped
          default:   d.ptr = q.ptr;
        endcase
      end
    end

    // Prefetch for the link; the pointer itself never goes out
    if (ev[1]) begin
      // Link loads rd_byte at the edge that asks for the next one, so keep it
      d.rd_sent = q.rd_byte;
      case (q.ptr)
        OFS_IN:    d.rd_byte = sensed;
        OFS_OUT:   d.rd_byte = q.outr;
        OFS_INV:   d.rd_byte = q.inv;
        OFS_DIR:   d.rd_byte = q.dir;
        OFS_DRV0:  d.rd_byte = q.drv0;
        OFS_DRV1:  d.rd_byte = q.drv1;
        OFS_HOLD:  d.rd_byte = q.hold;
        OFS_PEN:   d.rd_byte = q.pen;
        OFS_PDIR:  d.rd_byte = q.pdir;
        OFS_MASK:  d.rd_byte = q.mask;
        OFS_FLAGS: d.rd_byte = flags;
        OFS_STAGE: d.rd_byte = q.stage;
        default:   d.rd_byte = 8'h00;
      endcase
    end

    // Input port byte actually sent becomes the compare value, not the newer prefetch
    if (ev[2] && q.ptr == OFS_IN) begin
      d.shadow = q.rd_sent;
    end

    // Open-drain bank drives only lows; inputs never driven
    d.port_oe = ~d.dir & (d.stage[STAGE_OD_BIT] ? ~d.outr : 8'hFF);
    d.int_oe = |((sensed ^ d.shadow) & q.dir & ~q.mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register

  always_ff @(posedge CLK_SYS or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
      q.outr <= RST_OUT;
      q.inv <= RST_INV;
      q.dir <= RST_DIR;
      q.drv0 <= RST_DRV;
      q.drv1 <= RST_DRV;
      q.hold <= RST_HOLD;
      q.pen <= RST_PEN;
      q.pdir <= RST_PDIR;
      q.mask <= RST_MASK;
      q.stage <= RST_STAGE;
    end else begin
      q <= d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from the state register

  assign PORT_PIN_O = q.outr;
  assign PORT_PIN_OE = q.port_oe;
  assign PAD_DRIVE = {q.drv1, q.drv0};
  assign PAD_PULL_EN = q.pen;
  assign PAD_PULL_UP = q.pdir;
  // Line is only ever pulled low or let go
  assign INT_N_O = q.low;
  assign INT_N_OE = q.int_oe;
  assign SDA_O = q.low;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge CLK_SYS);
  endclocking
  default disable iff (!RSTN);

  dir_input_a: assert property ((PORT_PIN_OE & q.dir) == 8'h00)
    else $error("input pin is being driven");

  out_drive_a: assert property (!q.stage[STAGE_OD_BIT] |-> (PORT_PIN_OE == ~q.dir))
    else $error("output pin not driven from the out register");

  ptr_load_a: assert property ((ev[0] && lk.wr_cmd) |=> (q.ptr == $past(lk.wr_byte)))
    else $error("command byte did not reach the pointer");

  in_ro_a: assert property ((ev[0] && !lk.wr_cmd && q.ptr == OFS_IN) |=>
    ($stable(q.outr) && $stable(q.inv) && $stable(q.dir) && $stable(q.mask) &&
     $stable(q.ptr) && $stable(q.stage)))
    else $error("write to input port changed state");

  out_keep_a: assert property ((ev[0] && !lk.wr_cmd && q.ptr == OFS_OUT) |=>
    (q.outr == $past(lk.wr_byte)) ##1 (q.outr == $past(lk.wr_byte, 2)))
    else $error("output register lost the written byte");

  rd_pin_a: assert property ((ev[1] && q.ptr == OFS_IN) |=>
    (q.rd_byte == ($past(q.pin_f) ^ $past(q.inv))))
    else $error("input port read is not the pin level");

  rd_out_a: assert property ((ev[1] && q.ptr == OFS_OUT) |=> (q.rd_byte == $past(q.outr)))
    else $error("output port read is not the written value");

  rd_unknown_a: assert property ((ev[1] && q.ptr > OFS_DIR && q.ptr < OFS_DRV0) |=>
    (q.rd_byte == 8'h00))
    else $error("unknown command read not zero");

  irq_raise_a: assert property ((q.init_cnt == SETTLE_CYC && !ev[2] &&
    ((sensed ^ q.shadow) & q.dir & ~q.mask) != 8'h00) |=> INT_N_OE)
    else $error("pin change did not raise the interrupt");

  irq_masked_a: assert property ((q.mask == 8'hFF) [*2] |-> !INT_N_OE)
    else $error("masked pins raised the interrupt");

  irq_od_a: assert property (INT_N_O == 1'b0)
    else $error("interrupt line driven high");
endmodule
`default_nettype wire

/* test/gpx_i2c_mst.sv */
// I2C bus master model that drives the expander's serial side.
// Assumes a pull-up on SDA; SCL stands high between frames.
`timescale 1ns/1ps
`default_nettype none
module gpx_i2c_mst (
  // Bus lines
  output logic      scl,
  output wire logic sda,
  // Device pull-down request
  input  wire logic sda_oe
);
  logic pull_low;

  initial begin
    scl      = 1'h1;
    pull_low = 1'h0;
  end

  // Either party may pull low; released line floats high
  assign sda = ~(pull_low | sda_oe);

  // One bit: data set while SCL low, sampled mid-high
  task automatic bit_io(input logic b, output logic r);
    #16 pull_low = ~b;
    #16 scl = 1'h1;
    #16 r = sda;
    #16 scl = 1'h0;
  endtask

  // Also serves as repeated start
  task automatic start();
    #3 pull_low = 1'h0;
    #16 scl = 1'h1;
    #16 pull_low = 1'h1;
    #16 scl = 1'h0;
  endtask

  task automatic stop();
    #16 pull_low = 1'h1;
    #16 scl = 1'h1;
    #16 pull_low = 1'h0;
    #16;
  endtask

  task automatic wb(input logic [7:0] v, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(v[i], r);
    end
    bit_io(1'h1, r);
    ack = ~r;
  endtask

  // Last byte gets a NACK so the device lets go of the line
  task automatic rb(output logic [7:0] v, input logic nack);
    logic r;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'h1, v[i]);
    end
    bit_io(nack, r);
  endtask
endmodule
`default_nettype wire

/* test/tb_gpx_expander.sv */
// Self-checking bench: register model compared with the expander at every read.
// Assumes the I2C master model gpx_i2c_mst on the serial side.
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module tb_gpx_expander;
  import gpx_pkg::*;
  logic        clk_sys = 1'h0;
  logic        rstn = 1'h0;
  logic        strap_lo = 1'h0;
  logic        strap_hi = 1'h0;
  logic [7:0]  pins = 8'h00;
  wire logic   scl;
  wire logic   sda;
  logic        sda_o, sda_oe, int_n_o, int_n_oe;
  logic [7:0]  pin_o, pin_oe, pull_en, pull_up, inr;
  logic [15:0] drive;
  logic [7:0]  mdl [256];
  int          n_fail = 0;
  int          total_checks = 0;
  localparam logic [7:0] OFS [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h40, 8'h41,
                                      8'h42, 8'h43, 8'h44, 8'h45, 8'h46, 8'h4F};
  localparam logic [7:0] RSTV [12] = '{8'h00, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF,
                                       8'h00, 8'h00, 8'hFF, 8'hFF, 8'h00, 8'h00};

  always #4 clk_sys = ~clk_sys;

  gpx_expander u_gpx_expander (.CLK_SYS(clk_sys), .RSTN(rstn), .SCL(scl), .SDA_I(sda),
    .SDA_O(sda_o), .SDA_OE(sda_oe), .ADDR_STRAP_LO(strap_lo), .ADDR_STRAP_HI(strap_hi),
    .PORT_PIN_I(pins), .PORT_PIN_O(pin_o), .PORT_PIN_OE(pin_oe), .PAD_DRIVE(drive),
    .PAD_PULL_EN(pull_en), .PAD_PULL_UP(pull_up), .INT_N_O(int_n_o), .INT_N_OE(int_n_oe));
  gpx_i2c_mst u_gpx_i2c_mst (.scl(scl), .sda(sda), .sda_oe(sda_oe));

  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic rw(input logic [7:0] c);
    return c inside {8'h01, 8'h02, 8'h03, 8'h40, 8'h41, 8'h42, 8'h43, 8'h44, 8'h45, 8'h4F};
  endfunction

  function automatic logic [7:0] flags();
    return (pins ^ mdl[8'h02] ^ inr) & mdl[8'h03] & ~mdl[8'h45];
  endfunction

  task automatic clks(input int n);
    repeat (n) @(negedge clk_sys);
  endtask

  task automatic addr(input logic rd, input logic [1:0] s, output logic ack);
    u_gpx_i2c_mst.start();
    u_gpx_i2c_mst.wb({5'h1C, s, rd}, ack);
  endtask

  task automatic wreg(input logic [7:0] c, input logic [7:0] d);
    logic a;
    addr(1'h0, {strap_hi, strap_lo}, a);
    `CHK(a, 1'h1)
    u_gpx_i2c_mst.wb(c, a);
    `CHK(a, 1'h1)
    u_gpx_i2c_mst.wb(d, a);
    `CHK(a, 1'h1)
    u_gpx_i2c_mst.stop();
    clks(10);
    if (rw(c)) mdl[c] = d;
  endtask

  task automatic rreg(input logic [7:0] c);
    logic a;
    logic [7:0] v, e;
    addr(1'h0, {strap_hi, strap_lo}, a);
    u_gpx_i2c_mst.wb(c, a);
    u_gpx_i2c_mst.stop();
    addr(1'h1, {strap_hi, strap_lo}, a);
    `CHK(a, 1'h1)
    u_gpx_i2c_mst.rb(v, 1'h1);
    u_gpx_i2c_mst.stop();
    e = rw(c) ? mdl[c] : (c == 8'h00) ? pins ^ mdl[8'h02] : (c == 8'h46) ? flags() : 8'h00;
    if (c == 8'h00) inr = e;
    `CHK(v, e)
    clks(10);
  endtask

  task automatic chk_pads();
    `CHK(pin_o, mdl[8'h01])
    `CHK(pin_oe, (~mdl[8'h03] & (mdl[8'h4F][0] ? ~mdl[8'h01] : 8'hFF)))
    `CHK(drive, ({mdl[8'h41], mdl[8'h40]}))
    `CHK(pull_en, mdl[8'h43])
    `CHK(pull_up, mdl[8'h44])
    `CHK(int_n_oe, |flags())
    `CHK(({int_n_o, sda_o}), 2'h0)
  endtask

  task automatic all_regs();
    for (int k = 0; k < 12; k++) rreg(OFS[k]);
  endtask

  // Outputs are checked while reset is still held
  task automatic do_reset();
    @(negedge clk_sys);
    rstn = 1'h0;
    foreach (mdl[i]) mdl[i] = 8'h00;
    for (int k = 0; k < 12; k++) mdl[OFS[k]] = RSTV[k];
    inr = pins;
    clks(6);
    chk_pads();
    rstn = 1'h1;
    clks(12);
  endtask

  task automatic setpins(input logic [7:0] v);
    @(negedge clk_sys);
    pins = v;
    clks(10);
  endtask

  task automatic wrap_up();
    $display("checks %0d failures %0d", total_checks, n_fail);
    if (n_fail == 0 && total_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #600000;
    n_fail++;
    $display("watchdog expired");
    wrap_up();
  end

  initial begin
    logic a;
    int k;
    logic [7:0] v;
    void'($urandom(32'h1f7b));
    pins = 8'($urandom);
    do_reset();
    all_regs();
    chk_pads();
    $display("test reset defaults done");
    for (int i = 0; i < 12; i++) if (rw(OFS[i])) wreg(OFS[i], 8'($urandom));
    all_regs();
    chk_pads();
    // Repeated start, then two bytes in one read: same register, no increment
    addr(1'h0, {strap_hi, strap_lo}, a);
    u_gpx_i2c_mst.wb(8'h01, a);
    addr(1'h1, {strap_hi, strap_lo}, a);
    `CHK(a, 1'h1)
    u_gpx_i2c_mst.rb(v, 1'h0);
    `CHK(v, mdl[8'h01])
    u_gpx_i2c_mst.rb(v, 1'h1);
    `CHK(v, mdl[8'h01])
    u_gpx_i2c_mst.stop();
    clks(10);
    $display("test register readback done");
    wreg(8'h00, ~pins);
    wreg(8'h46, 8'hFF);
    for (int i = 0; i < 4; i++) begin
      k = (i == 0) ? 8'h04 : (i == 1) ? 8'h10 : (i == 2) ? 8'h47 : 8'h80;
      wreg(8'(k), 8'($urandom));
      rreg(8'(k));
    end
    all_regs();
    chk_pads();
    $display("test read-only and unknown codes done");
    repeat (4) begin
      setpins(8'($urandom));
      rreg(8'h00);
      chk_pads();
    end
    $display("test pin levels done");
    wreg(8'h03, 8'hFF);
    wreg(8'h02, 8'h00);
    wreg(8'h45, 8'h00);
    rreg(8'h00);
    chk_pads();
    k = $urandom_range(7);
    setpins(pins ^ (8'h01 << k));
    chk_pads();
    rreg(8'h46);
    rreg(8'h00);
    chk_pads();
    wreg(8'h45, 8'(8'h01 << k));
    setpins(pins ^ (8'h01 << k));
    chk_pads();
    wreg(8'h45, 8'h00);
    chk_pads();
    $display("test interrupt done");
    for (int s = 0; s < 4; s++) begin
      {strap_hi, strap_lo} = 2'(s);
      clks(12);
      addr(1'h0, 2'(s + 1), a);
      `CHK(a, 1'h0)
      u_gpx_i2c_mst.stop();
      clks(4);
      wreg(8'h01, 8'($urandom));
      rreg(8'h01);
    end
    $display("test address straps done");
    do_reset();
    all_regs();
    chk_pads();
    $display("test second reset done");
    wrap_up();
  end
endmodule
`default_nettype wire
